/* File: core/dma_chan_ctrl.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module dma_chan_ctrl (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// transfer engine status per channel
	input wire logic [7:0] xfer_active_i,
	input wire logic [7:0] burst_active_i,
	input wire logic [7:0] sw_trigger_i,
	input wire logic [7:0] evt_cond_i,
	// peripheral requests, bit n is request code n
	input wire logic [19:1] periph_req_i,
	// incoming events per channel
	input wire logic [7:0] evt_in_i,
	// channel control outputs
	output logic [7:0] chan_enable_o,
	output logic [7:0] chan_abort_o,
	output logic [7:0] chan_suspend_o,
	output logic [7:0] chan_resume_o,
	output logic [7:0][1:0] request_granularity_o,
	output logic [7:0][1:0] arb_priority_o,
	// event action outputs
	output logic [7:0] evt_trigger_o,
	output logic [7:0] evt_cond_trigger_o,
	output logic [7:0] evt_cond_block_o,
	output logic [7:0] evt_skip_pause_o,
	output logic [7:0] event_out_o,
	// arbitration result
	output logic grant_valid_o,
	output logic [2:0] grant_chan_o,
	output logic [1:0] grant_level_o
);
	localparam int unsigned N = dma_chan_pkg::NUM_CHAN;

	// selected peripheral request present for a channel
	function automatic logic periph_hit(input logic [4:0] src, input logic [19:1] req);
		logic hit;
		hit = 1'b0;
		if (src != dma_chan_pkg::SRC_NONE && src <= dma_chan_pkg::SRC_LAST)
			hit = req[src];
		return hit;
	endfunction : periph_hit

	// address decode shared by read and write paths
	function automatic logic [1:0] reg_index(input logic [11:0] a);
		logic [1:0] idx;
		case (a)
			dma_chan_pkg::ADDR_CHAN_SELECTOR: idx = 2'h1;
			dma_chan_pkg::ADDR_CHAN_CONTROL_A: idx = 2'h2;
			dma_chan_pkg::ADDR_CHAN_CONTROL_B: idx = 2'h3;
			default: idx = 2'h0;
		endcase
		return idx;
	endfunction : reg_index

	logic [2:0] sel_ff, nxt_sel;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] idx;
	logic wr_access;
	logic [N-1:0] wr_a;
	logic [N-1:0] wr_b;
	dma_chan_pkg::chan_cfg_t wr_cfg;
	dma_chan_pkg::chan_state_t st [N];
	dma_chan_pkg::chan_cfg_t cfg [N];
	logic [N-1:0] abort;
	logic [N-1:0] sw_susp;
	logic [N-1:0] sw_res;

	// bus decode; zero wait states so every access finishes in two cycles
	assign idx = reg_index(paddr_i);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && (idx == 2'h0);
	assign wr_access = psel_i && penable_i && pwrite_i && (idx != 2'h0);
	assign prdata_o = rdata_ff;

	// a byte-strobed write of the low byte carries the whole selector
	always_comb
	begin
		nxt_sel = sel_ff;
		if (wr_access && idx == 2'h1 && pstrb_i[0])
			nxt_sel = pwdata_i[2:0];
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			sel_ff <= dma_chan_pkg::CHAN_SELECTOR_RST;
		else
			sel_ff <= nxt_sel;
	end

	// write strobes reach only the channel held in the selector
	always_comb
	begin
		wr_a = '0;
		wr_b = '0;
		if (wr_access && idx == 2'h2 && pstrb_i[0])
			wr_a[sel_ff] = 1'b1;
		if (wr_access && idx == 2'h3)
			wr_b[sel_ff] = 1'b1;
	end

	// unstrobed lanes keep the channel's current field values
	always_comb
	begin
		logic [31:0] merged;
		merged = dma_chan_pkg::pack_control_b(cfg[sel_ff]);
		for (int b = 0; b < 4; b++)
		begin
			if (pstrb_i[b])
				merged[b*8 +: 8] = pwdata_i[b*8 +: 8];
		end
		wr_cfg = dma_chan_pkg::unpack_control_b(merged);
	end

	// one private slot per channel
	for (genvar c = 0; c < N; c++)
	begin : g_slot
		dma_chan_slot u_slot (
			.ref_clk_i(ref_clk_i),
			.nrst_i(nrst_i),
			.wr_a_i(wr_a[c]),
			.wr_enable_i(pwdata_i[dma_chan_pkg::POS_ENABLE]),
			.wr_soft_reset_i(pwdata_i[dma_chan_pkg::POS_SOFT_RESET]),
			.wr_b_i(wr_b[c]),
			.wr_cfg_i(wr_cfg),
			.xfer_active_i(xfer_active_i[c]),
			.burst_active_i(burst_active_i[c]),
			.state_o(st[c]),
			.cfg_o(cfg[c]),
			.abort_o(abort[c]),
			.sw_suspend_o(sw_susp[c]),
			.sw_resume_o(sw_res[c])
		);
	end

	// read data captured in the setup cycle, reserved bits zero
	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (psel_i && !penable_i && !pwrite_i)
		begin
			nxt_rdata = 32'h00000000;
			case (idx)
				2'h1: nxt_rdata[2:0] = sel_ff;
				2'h2:
				begin
					nxt_rdata[dma_chan_pkg::POS_ENABLE] = st[sel_ff].enable;
					nxt_rdata[dma_chan_pkg::POS_SOFT_RESET] = st[sel_ff].soft_reset_busy;
				end
				2'h3: nxt_rdata = dma_chan_pkg::pack_control_b(cfg[sel_ff]);
				default: nxt_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rdata_ff <= 32'h00000000;
		else
			rdata_ff <= nxt_rdata;
	end

	// event input decode and event output, one cycle behind their cause
	logic [N-1:0] ev_trig_ff, nxt_ev_trig;
	logic [N-1:0] ev_conditional_trigger_ff, nxt_ev_conditional_trigger;
	logic [N-1:0] ev_cblk_ff, nxt_ev_cblk;
	logic [N-1:0] ev_skip_ff, nxt_ev_skip;
	logic [N-1:0] susp_ff, nxt_susp;
	logic [N-1:0] res_ff, nxt_res;
	logic [N-1:0] evout_ff, nxt_evout;
	logic [N-1:0] abort_ff, nxt_abort;

	always_comb
	begin
		for (int c = 0; c < N; c++)
		begin
			nxt_ev_trig[c] = 1'b0;
			nxt_ev_conditional_trigger[c] = 1'b0;
			nxt_ev_cblk[c] = 1'b0;
			nxt_ev_skip[c] = 1'b0;
			nxt_susp[c] = sw_susp[c];
			nxt_res[c] = sw_res[c];
			nxt_abort[c] = abort[c];
			// events are dropped unless the channel accepts them
			if (evt_in_i[c] && cfg[c].event_in_enable)
			begin
				case (cfg[c].evact)
					dma_chan_pkg::EVACT_TRIGGER: nxt_ev_trig[c] = 1'b1;
					dma_chan_pkg::EVACT_CONDITIONAL_TRIGGER: nxt_ev_conditional_trigger[c] = 1'b1;
					dma_chan_pkg::EVACT_CONDITIONAL_BLOCK: nxt_ev_cblk[c] = 1'b1;
					dma_chan_pkg::EVACT_SUSPEND: nxt_susp[c] = 1'b1;
					dma_chan_pkg::EVACT_RESUME: nxt_res[c] = 1'b1;
					dma_chan_pkg::EVACT_SKIP_NEXT_BLOCK_PAUSE: nxt_ev_skip[c] = 1'b1;
					default: nxt_ev_trig[c] = 1'b0;
				endcase
			end
			// non-capable channels keep the bit but it drives nothing
			nxt_evout[c] = evt_cond_i[c] && cfg[c].event_out_enable && dma_chan_pkg::EVOUT_CAPABLE[c];
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ev_trig_ff <= '0;
			ev_conditional_trigger_ff <= '0;
			ev_cblk_ff <= '0;
			ev_skip_ff <= '0;
			susp_ff <= '0;
			res_ff <= '0;
			evout_ff <= '0;
			abort_ff <= '0;
		end
		else
		begin
			ev_trig_ff <= nxt_ev_trig;
			ev_conditional_trigger_ff <= nxt_ev_conditional_trigger;
			ev_cblk_ff <= nxt_ev_cblk;
			ev_skip_ff <= nxt_ev_skip;
			susp_ff <= nxt_susp;
			res_ff <= nxt_res;
			evout_ff <= nxt_evout;
			abort_ff <= nxt_abort;
		end
	end

	// arbitration: highest level first, lowest channel number breaks ties
	logic grant_valid_ff, nxt_grant_valid;
	logic [2:0] grant_chan_ff, nxt_grant_chan;
	logic [1:0] grant_level_ff, nxt_grant_level;

	always_comb
	begin
		logic req;
		req = 1'b0;
		nxt_grant_valid = 1'b0;
		nxt_grant_chan = 3'h0;
		nxt_grant_level = 2'h0;
		for (int c = 0; c < N; c++)
		begin
			req = st[c].enable && (sw_trigger_i[c] || periph_hit(cfg[c].src, periph_req_i));
			// strict greater keeps the lower index on equal level
			if (req && (!nxt_grant_valid || cfg[c].prio > nxt_grant_level))
			begin
				nxt_grant_valid = 1'b1;
				nxt_grant_chan = 3'(c);
				nxt_grant_level = cfg[c].prio;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			grant_valid_ff <= 1'b0;
			grant_chan_ff <= 3'h0;
			grant_level_ff <= 2'h0;
		end
		else
		begin
			grant_valid_ff <= nxt_grant_valid;
			grant_chan_ff <= nxt_grant_chan;
			grant_level_ff <= nxt_grant_level;
		end
	end

	// per-channel field outputs straight from the slot registers
	always_comb
	begin
		for (int c = 0; c < N; c++)
		begin
			chan_enable_o[c] = st[c].enable;
			request_granularity_o[c] = cfg[c].gran;
			arb_priority_o[c] = cfg[c].prio;
		end
	end

	assign chan_abort_o = abort_ff;
	assign chan_suspend_o = susp_ff;
	assign chan_resume_o = res_ff;
	assign evt_trigger_o = ev_trig_ff;
	assign evt_cond_trigger_o = ev_conditional_trigger_ff;
	assign evt_cond_block_o = ev_cblk_ff;
	assign evt_skip_pause_o = ev_skip_ff;
	assign event_out_o = evout_ff;
	assign grant_valid_o = grant_valid_ff;
	assign grant_chan_o = grant_chan_ff;
	assign grant_level_o = grant_level_ff;
endmodule : dma_chan_ctrl

/* File: pkg/dma_chan_pkg.sv */
package dma_chan_pkg;
	// channel count follows the 3-bit channel number field
	localparam int unsigned CHAN_W = 3;
	localparam int unsigned NUM_CHAN = 8;
	localparam int unsigned NUM_PERIPH = 19;
	localparam int unsigned ADDR_W = 12;

	// register byte addresses
	localparam logic [11:0] ADDR_CHAN_SELECTOR = 12'h03c;
	localparam logic [11:0] ADDR_CHAN_CONTROL_A = 12'h040;
	localparam logic [11:0] ADDR_CHAN_CONTROL_B = 12'h044;

	// reset values
	localparam logic [2:0] CHAN_SELECTOR_RST = 3'h0;
	localparam logic [7:0] CHAN_CONTROL_A_RST = 8'h00;
	localparam logic [31:0] CHAN_CONTROL_B_RST = 32'h00000000;

	// chan_control_a field positions
	localparam int unsigned POS_SOFT_RESET = 0;
	localparam int unsigned POS_ENABLE = 1;

	// chan_control_b field positions
	localparam int unsigned POS_CMD = 24;
	localparam int unsigned POS_GRAN = 22;
	localparam int unsigned POS_SRC = 8;
	localparam int unsigned POS_PRIO = 5;
	localparam int unsigned POS_EVENT_OUT_ENABLE = 4;
	localparam int unsigned POS_EVENT_IN_ENABLE = 3;
	localparam int unsigned POS_EVACT = 0;

	// software commands
	localparam logic [1:0] CMD_NO_ACTION = 2'h0;
	localparam logic [1:0] CMD_SUSPEND = 2'h1;
	localparam logic [1:0] CMD_RESUME = 2'h2;

	// request granularity codes
	localparam logic [1:0] GRAN_BLOCK = 2'h0;
	localparam logic [1:0] GRAN_BEAT = 2'h2;
	localparam logic [1:0] GRAN_TRANSACTION = 2'h3;

	// peripheral request select: zero means software or event triggers only
	localparam logic [4:0] SRC_NONE = 5'h00;
	localparam logic [4:0] SRC_LAST = 5'h13;

	// event input actions
	localparam logic [2:0] EVACT_NO_ACTION = 3'h0;
	localparam logic [2:0] EVACT_TRIGGER = 3'h1;
	localparam logic [2:0] EVACT_CONDITIONAL_TRIGGER = 3'h2;
	localparam logic [2:0] EVACT_CONDITIONAL_BLOCK = 3'h3;
	localparam logic [2:0] EVACT_SUSPEND = 3'h4;
	localparam logic [2:0] EVACT_RESUME = 3'h5;
	localparam logic [2:0] EVACT_SKIP_NEXT_BLOCK_PAUSE = 3'h6;

	// channels that carry event output logic
	localparam logic [7:0] EVOUT_CAPABLE = 8'h0f;

	// soft reset duration
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned SRST_TIME_NS = 40;
	localparam int unsigned SRST_CYCLES_RAW = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SRST_CYCLES = (SRST_CYCLES_RAW < 1) ? 4'h1 : 4'(SRST_CYCLES_RAW);

	typedef struct packed {
		logic [1:0] cmd;
		logic [1:0] gran;
		logic [4:0] src;
		logic [1:0] prio;
		logic event_out_enable;
		logic event_in_enable;
		logic [2:0] evact;
	} chan_cfg_t;

	localparam chan_cfg_t CHAN_CFG_RST = '{default: '0};

	typedef struct packed {
		logic enable;
		logic soft_reset_busy;
	} chan_state_t;

	// pack channel configuration into the chan_control_b word, reserved bits zero
	function automatic logic [31:0] pack_control_b(input chan_cfg_t c);
		logic [31:0] w;
		w = 32'h00000000;
		w[POS_CMD +: 2] = c.cmd;
		w[POS_GRAN +: 2] = c.gran;
		w[POS_SRC +: 5] = c.src;
		w[POS_PRIO +: 2] = c.prio;
		w[POS_EVENT_OUT_ENABLE] = c.event_out_enable;
		w[POS_EVENT_IN_ENABLE] = c.event_in_enable;
		w[POS_EVACT +: 3] = c.evact;
		return w;
	endfunction : pack_control_b

	function automatic chan_cfg_t unpack_control_b(input logic [31:0] w);
		chan_cfg_t c;
		c.cmd = w[POS_CMD +: 2];
		c.gran = w[POS_GRAN +: 2];
		c.src = w[POS_SRC +: 5];
		c.prio = w[POS_PRIO +: 2];
		c.event_out_enable = w[POS_EVENT_OUT_ENABLE];
		c.event_in_enable = w[POS_EVENT_IN_ENABLE];
		c.evact = w[POS_EVACT +: 3];
		return c;
	endfunction : unpack_control_b
endpackage : dma_chan_pkg

/* File: core/dma_chan_slot.sv */
`timescale 1ns/1ps
// one channel's private control state
module dma_chan_slot (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// register writes already routed to this channel
	input wire logic wr_a_i,
	input wire logic wr_enable_i,
	input wire logic wr_soft_reset_i,
	input wire logic wr_b_i,
	input wire dma_chan_pkg::chan_cfg_t wr_cfg_i,
	// transfer engine status
	input wire logic xfer_active_i,
	input wire logic burst_active_i,
	// state
	output dma_chan_pkg::chan_state_t state_o,
	output dma_chan_pkg::chan_cfg_t cfg_o,
	output logic abort_o,
	output logic sw_suspend_o,
	output logic sw_resume_o
);
	typedef enum logic [1:0] {ST_OFF, ST_ON, ST_STOPPING, ST_RESETTING} slot_st_t;

	slot_st_t st_ff, nxt_st;
	dma_chan_pkg::chan_cfg_t cfg_ff, nxt_cfg;
	logic [3:0] cnt_ff, nxt_cnt;
	logic abort_ff, nxt_abort;
	logic susp_ff, nxt_susp;
	logic res_ff, nxt_res;
	logic en;

	// enable reads one until a pending stop has drained
	assign en = (st_ff == ST_ON) || (st_ff == ST_STOPPING);
	assign state_o.enable = en;
	assign state_o.soft_reset_busy = (st_ff == ST_RESETTING);
	assign cfg_o = cfg_ff;
	assign abort_o = abort_ff;
	assign sw_suspend_o = susp_ff;
	assign sw_resume_o = res_ff;

	// channel state and configuration next values
	always_comb
	begin
		nxt_st = st_ff;
		nxt_cfg = cfg_ff;
		nxt_cnt = cnt_ff;
		nxt_abort = 1'b0;
		nxt_susp = 1'b0;
		nxt_res = 1'b0;
		case (st_ff)
			ST_OFF:
			begin
				if (wr_a_i && wr_soft_reset_i)
				begin
					// soft reset only accepted while disabled
					nxt_st = ST_RESETTING;
					nxt_cfg = dma_chan_pkg::CHAN_CFG_RST;
					nxt_cnt = dma_chan_pkg::SRST_CYCLES;
				end
				else if (wr_a_i && wr_enable_i)
					nxt_st = ST_ON;
			end
			ST_ON:
			begin
				// soft reset writes fall through unused here
				if (wr_a_i && !wr_enable_i)
				begin
					if (xfer_active_i)
						nxt_st = ST_STOPPING;
					else
						nxt_st = ST_OFF;
				end
			end
			ST_STOPPING:
			begin
				if (wr_a_i && wr_enable_i)
					nxt_st = ST_ON;
				else if (!burst_active_i)
				begin
					// buffer counts as empty once the running burst ends
					nxt_st = ST_OFF;
					nxt_abort = 1'b1;
				end
			end
			ST_RESETTING:
			begin
				nxt_cfg = dma_chan_pkg::CHAN_CFG_RST;
				nxt_cnt = cnt_ff - 4'h1;
				if (cnt_ff == 4'h1)
					nxt_st = ST_OFF;
			end
			default:
				nxt_st = ST_OFF;
		endcase
		// config writes; enable protection spares command and level only
		if (wr_b_i && st_ff != ST_RESETTING)
		begin
			nxt_cfg.cmd = wr_cfg_i.cmd;
			nxt_cfg.prio = wr_cfg_i.prio;
			if (!en)
			begin
				nxt_cfg.gran = wr_cfg_i.gran;
				nxt_cfg.src = wr_cfg_i.src;
				nxt_cfg.event_out_enable = wr_cfg_i.event_out_enable;
				nxt_cfg.event_in_enable = wr_cfg_i.event_in_enable;
				nxt_cfg.evact = wr_cfg_i.evact;
			end
			nxt_susp = (wr_cfg_i.cmd == dma_chan_pkg::CMD_SUSPEND);
			nxt_res = (wr_cfg_i.cmd == dma_chan_pkg::CMD_RESUME);
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_ff <= ST_OFF;
			cfg_ff <= dma_chan_pkg::CHAN_CFG_RST;
			cnt_ff <= 4'h0;
			abort_ff <= 1'b0;
			susp_ff <= 1'b0;
			res_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			cfg_ff <= nxt_cfg;
			cnt_ff <= nxt_cnt;
			abort_ff <= nxt_abort;
			susp_ff <= nxt_susp;
			res_ff <= nxt_res;
		end
	end
endmodule : dma_chan_slot

/* File: tb/dma_chan_checker.sv */
`timescale 1ns/1ps
// watches the register port and per-channel control outputs
module dma_chan_checker (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	// channel side
	input wire logic [7:0] xfer_active_i,
	input wire logic [7:0] burst_active_i,
	input wire logic [7:0] evt_cond_i,
	input wire logic [7:0] evt_in_i,
	input wire logic [7:0] chan_enable_o,
	input wire logic [7:0] chan_abort_o,
	input wire logic [7:0] evt_trigger_o,
	input wire logic [7:0] event_out_o,
	input wire logic grant_valid_o,
	input wire logic [2:0] grant_chan_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	logic hit;
	logic [7:0] en_prev_ff;
	logic [7:0] nxt_en_prev;
	// address decode of the three mapped words
	assign hit = paddr_i inside {dma_chan_pkg::ADDR_CHAN_SELECTOR, dma_chan_pkg::ADDR_CHAN_CONTROL_A,
		dma_chan_pkg::ADDR_CHAN_CONTROL_B};
	// enable as the arbiter saw it one cycle back
	always_comb nxt_en_prev = chan_enable_o;
	always_ff @(posedge ref_clk_i or negedge nrst_i)
		if (!nrst_i)
			en_prev_ff <= 8'h00;
		else
			en_prev_ff <= nxt_en_prev;
	// setup then access phase of one transfer
	sequence s_rd(logic [11:0] a);
		psel_i && !penable_i && !pwrite_i && paddr_i == a ##1 psel_i && penable_i;
	endsequence
	sequence s_wr(logic [11:0] a);
		psel_i && !penable_i && pwrite_i && paddr_i == a ##1 psel_i && penable_i;
	endsequence
	bad_addr_err_a: assert property (psel_i && penable_i && !hit |-> pslverr_o)
		else $error("unmapped access without error");
	good_addr_ok_a: assert property (psel_i && penable_i && hit |-> !pslverr_o)
		else $error("error on mapped access");
	resv_a_zero_a: assert property (s_rd(dma_chan_pkg::ADDR_CHAN_CONTROL_A) |-> prdata_o[31:2] == 30'h0)
		else $error("control a reserved bits set");
	resv_b_zero_a: assert property (s_rd(dma_chan_pkg::ADDR_CHAN_CONTROL_B)
		|-> {prdata_o[31:26], prdata_o[21:13], prdata_o[7]} == 16'h0000)
		else $error("control b reserved bits set");
	enable_set_a: assert property (s_wr(dma_chan_pkg::ADDR_CHAN_CONTROL_A)
		##0 (pwdata_i[1] && pstrb_i[0]) |=> chan_enable_o != 8'h00)
		else $error("enable write lost");
	evout_capable_a: assert property ((event_out_o & ~dma_chan_pkg::EVOUT_CAPABLE) == 8'h00)
		else $error("event out on incapable channel");
	grant_enabled_a: assert property (grant_valid_o |-> en_prev_ff[grant_chan_o])
		else $error("grant to disabled channel");
	for (genvar c = 0; c < 8; c++)
	begin : g_ch
		burst_hold_a: assert property (chan_enable_o[c] && xfer_active_i[c] && burst_active_i[c]
			|=> chan_enable_o[c])
			else $error("enable dropped inside burst");
		abort_pulse_a: assert property (chan_abort_o[c] |-> !chan_enable_o[c] ##1 !chan_abort_o[c])
			else $error("abort malformed");
		evout_cause_a: assert property (event_out_o[c] |-> $past(evt_cond_i[c]))
			else $error("event out without condition");
		evtrig_cause_a: assert property (evt_trigger_o[c] |-> $past(evt_in_i[c]))
			else $error("trigger without event");
	end
endmodule : dma_chan_checker

/* File: tb/dma_far_side.sv */
`timescale 1ns/1ps
// stand-in for trigger sources, event channels and transfer engine
module dma_far_side (
	// clock
	input wire logic ref_clk_i,
	// levels toward the block
	output logic [7:0] xfer_active_o,
	output logic [7:0] burst_active_o,
	output logic [7:0] sw_trigger_o,
	output logic [19:1] periph_req_o,
	// event strobes toward the block
	output logic [7:0] evt_in_o,
	output logic [7:0] evt_cond_o
);
	// quiet at time zero
	initial
	begin
		{xfer_active_o, burst_active_o, sw_trigger_o, evt_in_o, evt_cond_o} = '0;
		periph_req_o = '0;
	end
	// levels hold until changed; return settled so callers never race an edge
	task automatic set_lv(input logic [7:0] x, input logic [7:0] b, input logic [7:0] s, input logic [19:1] r);
		@(posedge ref_clk_i);
		xfer_active_o <= x;
		burst_active_o <= b;
		sw_trigger_o <= s;
		periph_req_o <= r;
		#1;
	endtask : set_lv
	// events are single-cycle strobes
	task automatic pulse(input logic [7:0] e, input logic [7:0] c);
		@(posedge ref_clk_i);
		evt_in_o <= e;
		evt_cond_o <= c;
		@(posedge ref_clk_i);
		evt_in_o <= 8'h00;
		evt_cond_o <= 8'h00;
		#1;
	endtask : pulse
endmodule : dma_far_side

/* File: tb/tb_dma_channel_control_regs.sv */
`timescale 1ns/1ps
module tb_dma_channel_control_regs;
	localparam logic [11:0] SEL = dma_chan_pkg::ADDR_CHAN_SELECTOR;
	localparam logic [11:0] CA = dma_chan_pkg::ADDR_CHAN_CONTROL_A;
	localparam logic [11:0] CB = dma_chan_pkg::ADDR_CHAN_CONTROL_B;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h00000000;
	logic [31:0] prd, rdat;
	logic prdy, perr, erd, gv;
	logic [7:0] xa, ba, st, ei, ec, en, ab, sus, res, etr, ect, ecb, esk, eo;
	logic [19:1] pr;
	logic [7:0][1:0] gr, pri;
	logic [2:0] gc;
	logic [1:0] gl;
	int n_fail = 0;
	int n_checks = 0;
	// 50 MHz
	always #10 clk = ~clk;
	dma_far_side far (.ref_clk_i(clk), .xfer_active_o(xa), .burst_active_o(ba), .sw_trigger_o(st),
		.periph_req_o(pr), .evt_in_o(ei), .evt_cond_o(ec));
	dma_chan_ctrl uut (.ref_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(padr), .pwdata_i(pwd), .pstrb_i(4'hf), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
		.xfer_active_i(xa), .burst_active_i(ba), .sw_trigger_i(st), .evt_cond_i(ec), .periph_req_i(pr),
		.evt_in_i(ei), .chan_enable_o(en), .chan_abort_o(ab), .chan_suspend_o(sus), .chan_resume_o(res),
		.request_granularity_o(gr), .arb_priority_o(pri), .evt_trigger_o(etr), .evt_cond_trigger_o(ect),
		.evt_cond_block_o(ecb), .evt_skip_pause_o(esk), .event_out_o(eo), .grant_valid_o(gv),
		.grant_chan_o(gc), .grant_level_o(gl));
	task automatic ck(input logic [63:0] g, input logic [63:0] x);
		n_checks++;
		if (g !== x)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, x);
		end
	endtask : ck
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tk
	// apb master; leading edge keeps psel from two assignments in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		// no wait-state count assumed; only the watchdog ends a stuck wait
		while (prdy !== 1'b1)
			@(posedge clk);
		rdat = prd;
		erd = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		#1;
	endtask : apb
	task automatic t_reset();
		apb(0, SEL, 0);
		ck(rdat, 32'h0);
		apb(0, CA, 0);
		ck(rdat, 32'h0);
		apb(0, CB, 0);
		ck(rdat, 32'h0);
		apb(1, 12'h048, 32'hffffffff);
		ck(erd, 1'b1);
		apb(0, 12'h048, 0);
		ck({erd, rdat}, {1'b1, 32'h0});
	endtask : t_reset
	task automatic t_gran();
		apb(1, SEL, 0);
		for (int g = 0; g < 4; g++)
		begin
			apb(1, CB, 32'(g) << 22);
			apb(0, CB, 0);
			ck(rdat, 32'(g) << 22);
			if (g != 1)
				ck(gr[0], g[1:0]);
		end
	endtask : t_gran
	// every event action code accepted, plus one gated-off trigger, on a capable and a plain channel
	task automatic t_event();
		logic [5:0] v;
		for (int c = 1; c < 8; c += 4)
		begin
			apb(1, SEL, 3'(c));
			for (int a = 0; a < 9; a++)
			begin
				apb(1, CB, (a < 8) ? 32'h18 | 32'(a) : 32'h11);
				far.pulse(8'h1 << c, 8'h1 << c);
				v = {esk[c], res[c], sus[c], ecb[c], ect[c], etr[c]};
				ck(v, (a > 0 && a < 7) ? 6'h1 << (a - 1) : 6'h0);
				ck(eo[c], c < 4);
			end
		end
	endtask : t_event
	task automatic t_enable();
		int k;
		apb(1, SEL, 3);
		apb(1, CA, 2);
		ck(en[3], 1'b1);
		far.set_lv(8'h08, 8'h08, 0, 0);
		apb(1, CA, 0);
		tk(4);
		apb(0, CA, 0);
		ck({en[3], rdat}, {1'b1, 32'h2});
		far.set_lv(8'h08, 8'h00, 0, 0);
		k = 0;
		while (ab[3] !== 1'b1 && k < 8)
		begin
			k++;
			tk(1);
		end
		ck({ab[3], en[3]}, 2'b10);
		far.set_lv(0, 0, 0, 0);
	endtask : t_enable
	// live edits on an enabled channel, then soft reset refused and honoured
	task automatic t_live();
		apb(1, CA, 2);
		apb(1, CB, 32'h01c00060);
		// command pulse stands one cycle, one edge after the access edge
		tk(1);
		ck({sus[3], pri[3], gr[3]}, {1'b1, 2'h3, 2'h0});
		apb(0, CB, 0);
		ck(rdat, 32'h01000060);
		apb(1, CB, 32'h02000060);
		tk(1);
		ck({res[3], sus[3]}, 2'b10);
		apb(1, CA, 3);
		apb(0, CB, 0);
		ck(rdat, 32'h02000060);
		apb(1, CA, 0);
		apb(1, CA, 1);
		// read straight away still catches the reset in progress
		apb(0, CA, 0);
		ck(rdat, 32'h1);
		apb(0, CA, 0);
		ck(rdat, 32'h0);
		apb(0, CB, 0);
		ck(rdat, 32'h0);
		apb(1, SEL, 1);
		apb(0, CB, 0);
		ck(rdat, 32'h11);
	endtask : t_live
	task automatic t_grant();
		apb(1, SEL, 2);
		apb(1, CB, 32'h20);
		apb(1, CA, 2);
		apb(1, SEL, 6);
		for (int k = 1; k < 20; k++)
		begin
			apb(1, CA, 0);
			apb(1, CB, (32'(k) << 8) | 32'h40);
			apb(1, CA, 2);
			far.set_lv(0, 0, 0, ~(19'h1 << (k - 1)));
			tk(1);
			ck(gv, 1'b0);
			far.set_lv(0, 0, 0, 19'h1 << (k - 1));
			tk(1);
			ck({gv, gc, gl}, {1'b1, 3'h6, 2'h2});
		end
		far.set_lv(0, 0, 8'h44, 0);
		tk(1);
		ck({gv, gc, gl}, {1'b1, 3'h6, 2'h2});
		apb(1, SEL, 2);
		apb(1, CB, 32'h60);
		tk(3);
		ck({gv, gc, gl}, {1'b1, 3'h2, 2'h3});
		far.set_lv(0, 0, 0, 0);
	endtask : t_grant
	task automatic wrap_up();
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	initial
	begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_gran();
		t_event();
		t_enable();
		t_live();
		t_grant();
		wrap_up();
	end
	// hang guard, far beyond the five hundred or so cycles needed
	initial
	begin
		#400000;
		n_fail++;
		wrap_up();
	end
endmodule : tb_dma_channel_control_regs
bind dma_chan_ctrl dma_chan_checker chk_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
	.prdata_o(prdata_o), .pslverr_o(pslverr_o), .xfer_active_i(xfer_active_i), .burst_active_i(burst_active_i),
	.evt_cond_i(evt_cond_i), .evt_in_i(evt_in_i), .chan_enable_o(chan_enable_o), .chan_abort_o(chan_abort_o),
	.evt_trigger_o(evt_trigger_o), .event_out_o(event_out_o), .grant_valid_o(grant_valid_o),
	.grant_chan_o(grant_chan_o));
